// ===== core/parallel_host_register_port.sv
// byte-wide parallel host register port with message handshake and audio fifos
`timescale 1ns/1ns
module parallel_host_register_port #(
    parameter int depth     = host_port_pkg::fifo_depth_default,     // audio fifo words
    parameter int threshold = host_port_pkg::fifo_threshold_default  // almost-full level
) (
    input  wire logic       sys_clk,                 // system clock, 100 MHz
    input  wire logic       rst,                     // synchronous reset, active high
    input  wire logic       bus_style,               // 0 separate strobes, 1 data strobe with direction
    input  wire logic       chip_select_n,           // host chip select
    input  wire logic       write_strobe_n,          // separate style write strobe
    input  wire logic       read_strobe_n,           // separate style read strobe
    input  wire logic       data_strobe_n,           // strobe style data strobe
    input  wire logic       read_not_write,          // strobe style direction, high read
    input  wire logic [1:0] reg_addr,                // register address pins
    input  wire logic [7:0] data_in,                 // data pins as seen
    output logic      [7:0] data_out,                // data pins driven on read
    output logic            data_oe,                 // high while driving data pins
    output logic            host_interrupt_request_n,// active-low outgoing message request
    input  wire logic       dsp_inbox_read,          // dsp takes the inbox byte
    output logic      [7:0] dsp_inbox_data,          // inbox byte for the dsp
    input  wire logic       dsp_outbox_write,        // dsp loads the outbox
    input  wire logic [7:0] dsp_outbox_data,         // outbox byte from the dsp
    input  wire logic       dsp_notify_enable,       // firmware enables interrupt
    output logic            inbound_busy,            // inbox unread by dsp
    output logic            outbound_ready,          // outbox unread by host
    output logic      [7:0] pcm_out_data,            // pcm fifo head
    output logic            pcm_out_valid,           // pcm word available
    input  wire logic       pcm_out_ready,           // dsp takes pcm word
    output logic      [7:0] cmp_out_data,            // compressed fifo head
    output logic            cmp_out_valid,           // compressed word available
    input  wire logic       cmp_out_ready,           // dsp takes compressed word
    output logic            pcm_channel_reset,       // pcm channel held in reset
    output logic            compressed_channel_reset // compressed channel held in reset
);
    localparam int lw = $clog2(depth + 1);           // fifo level width

    // synchronised host pins
    logic       cs_n_s;                              // chip select
    logic       wr_n_s;                              // write strobe
    logic       rd_n_s;                              // read strobe
    logic       ds_n_s;                              // data strobe
    logic       rnw_s;                               // direction
    logic       style_s;                             // bus style
    logic [1:0] addr_s;                              // register address
    logic [7:0] din_s;                               // write data

    // strobe decode
    logic       wr_act;                              // write cycle active now
    logic       rd_act;                              // read cycle active now
    logic       wr_act_q;                            // previous write activity
    logic       rd_act_q;                            // previous read activity
    logic [1:0] addr_q;                              // address held during cycle
    logic [7:0] data_q;                              // data held during write
    logic       wr_end;                              // write cycle ended, one pulse
    logic       rd_start;                            // read cycle began, one pulse
    logic       rd_end;                              // read cycle ended, one pulse

    // register state
    logic [7:0] inbox_q;                             // host to dsp byte
    logic [7:0] outbox_q;                            // dsp to host byte
    logic       busy_q;                              // inbound busy flag
    logic       ready_q;                             // outbound ready flag
    logic       pcm_rst_q;                           // pcm channel reset bit
    logic       cmp_rst_q;                           // compressed channel reset bit
    logic       pcm_full_q;                          // pcm almost full, registered
    logic       cmp_full_q;                          // compressed almost full, registered

    // fifo wiring
    logic          pcm_push;                         // pcm write request, dropped when the fifo is full
    logic          cmp_push;                         // compressed write request, dropped when the fifo is full
    logic          pcm_in_ready;                     // pcm fifo room
    logic          cmp_in_ready;                     // compressed fifo room
    logic [lw-1:0] pcm_level;                        // pcm occupancy
    logic [lw-1:0] cmp_level;                        // compressed occupancy

    pin_sync #(.width(4), .reset_val(1'h1)) sync_ctl (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  ({chip_select_n, write_strobe_n, read_strobe_n, data_strobe_n}),
        .pin_out ({cs_n_s, wr_n_s, rd_n_s, ds_n_s})
    );

    pin_sync #(.width(12), .reset_val(1'h0)) sync_dat (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  ({read_not_write, bus_style, reg_addr, data_in}),
        .pin_out ({rnw_s, style_s, addr_s, din_s})
    );

    always_comb
    begin
        if (style_s)
        begin
            wr_act = !cs_n_s && !ds_n_s && !rnw_s;
            rd_act = !cs_n_s && !ds_n_s && rnw_s;
        end
        else
        begin
            wr_act = !cs_n_s && !wr_n_s;
            rd_act = !cs_n_s && !rd_n_s;
        end
    end

    // data and address are sampled while the strobe is low, so the
    // rising strobe edge commits the last stable value (setup held by host)
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            addr_q   <= 2'h0;
            data_q   <= host_port_pkg::byte_reset;
        end
        else
        begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            if (wr_act || rd_act)
                addr_q <= addr_s;
            if (wr_act)
                data_q <= din_s;
        end
    end

    assign wr_end   = wr_act_q && !wr_act;
    assign rd_start = rd_act && !rd_act_q;
    assign rd_end   = rd_act_q && !rd_act;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            inbox_q <= host_port_pkg::byte_reset;
        else if (wr_end && addr_q == host_port_pkg::addr_message)
            inbox_q <= data_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            outbox_q <= host_port_pkg::byte_reset;
        else if (dsp_outbox_write)
            outbox_q <= dsp_outbox_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            busy_q <= 1'b0;
        else if (wr_end && addr_q == host_port_pkg::addr_message)
            busy_q <= 1'b1;
        else if (dsp_inbox_read)
            busy_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ready_q <= 1'b0;
        else if (dsp_outbox_write)
            ready_q <= 1'b1;
        else if (rd_end && addr_q == host_port_pkg::addr_message)
            ready_q <= 1'b0;
    end

    // control bits; reserved bits 7 and 0 are ignored on write
    // pcm and compressed reset bits
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pcm_rst_q <= 1'b0;
            cmp_rst_q <= 1'b0;
        end
        else if (wr_end && addr_q == host_port_pkg::addr_control)
        begin
            cmp_rst_q <= data_q[host_port_pkg::bit_compressed_reset];
            pcm_rst_q <= data_q[host_port_pkg::bit_pcm_reset];
        end
    end

    // audio writes push fifos
    // a write while the fifo is full is dropped; the host must watch the flags
    assign pcm_push = wr_end && addr_q == host_port_pkg::addr_pcm;
    assign cmp_push = wr_end && addr_q == host_port_pkg::addr_compressed;

    byte_fifo #(.width(8), .depth(depth)) pcm_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst || pcm_rst_q),
        .in_data   (data_q),
        .in_valid  (pcm_push),
        .in_ready  (pcm_in_ready),
        .out_data  (pcm_out_data),
        .out_valid (pcm_out_valid),
        .out_ready (pcm_out_ready),
        .level     (pcm_level)
    );

    byte_fifo #(.width(8), .depth(depth)) cmp_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst || cmp_rst_q),
        .in_data   (data_q),
        .in_valid  (cmp_push),
        .in_ready  (cmp_in_ready),
        .out_data  (cmp_out_data),
        .out_valid (cmp_out_valid),
        .out_ready (cmp_out_ready),
        .level     (cmp_level)
    );

    // flags stall host audio
    // full fifo also raises the flag, so the host sees back-pressure
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pcm_full_q <= 1'b0;
            cmp_full_q <= 1'b0;
        end
        else
        begin
            pcm_full_q <= (pcm_level >= lw'(threshold)) || !pcm_in_ready;
            cmp_full_q <= (cmp_level >= lw'(threshold)) || !cmp_in_ready;
        end
    end

    // read data captured at the start of a read cycle and held until it ends
    // only two readable
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            data_out <= host_port_pkg::byte_reset;
        else if (rd_start)
        begin
            case (addr_s)
                host_port_pkg::addr_message:
                    data_out <= outbox_q;
                host_port_pkg::addr_control:
                    data_out <= {3'h0, pcm_full_q, cmp_full_q, busy_q, ready_q, 1'b0};
                default:
                    data_out <= host_port_pkg::byte_reset;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            data_oe <= 1'b0;
        else
            data_oe <= rd_act && (addr_s == host_port_pkg::addr_message ||
                                  addr_s == host_port_pkg::addr_control);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            host_interrupt_request_n <= 1'b1;
        else
            host_interrupt_request_n <= !(dsp_notify_enable && ready_q);
    end

    // registered copies for the dsp side
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            dsp_inbox_data           <= host_port_pkg::byte_reset;
            inbound_busy             <= 1'b0;
            outbound_ready           <= 1'b0;
            pcm_channel_reset        <= 1'b0;
            compressed_channel_reset <= 1'b0;
        end
        else
        begin
            dsp_inbox_data           <= inbox_q;
            inbound_busy             <= busy_q;
            outbound_ready           <= ready_q;
            pcm_channel_reset        <= pcm_rst_q;
            compressed_channel_reset <= cmp_rst_q;
        end
    end
endmodule

// ===== core/host_port_pkg.sv
// constants shared by the parallel host register port
package host_port_pkg;
    localparam logic [1:0] addr_message    = 2'h0;  // message byte register
    localparam logic [1:0] addr_control    = 2'h1;  // control and status
    localparam logic [1:0] addr_pcm        = 2'h2;  // pcm audio input
    localparam logic [1:0] addr_compressed = 2'h3;  // compressed audio input
    localparam int bit_compressed_reset    = 6;     // control write bit
    localparam int bit_pcm_reset           = 5;     // control write bit
    localparam int bit_pcm_almost_full     = 4;     // status read bit
    localparam int bit_cmp_almost_full     = 3;     // status read bit
    localparam int bit_inbound_busy        = 2;     // status read bit
    localparam int bit_outbound_ready      = 1;     // status read bit
    localparam logic [7:0] byte_reset      = 8'h00; // reset value of byte registers
    localparam int fifo_depth_default      = 8;     // audio fifo words
    localparam int fifo_threshold_default  = 6;     // almost-full level
    localparam int sync_stages             = 2;     // pin synchroniser length
endpackage

// ===== core/pin_sync.sv
// two flip-flop synchroniser for a bundle of host pins
`timescale 1ns/1ns
module pin_sync #(
    parameter int         width     = 1,     // bits synchronised
    parameter logic [0:0] reset_val = 1'h0   // idle level of every bit
) (
    input  wire logic             sys_clk,   // system clock
    input  wire logic             rst,       // synchronous reset
    input  wire logic [width-1:0] pin_in,    // asynchronous pins
    output logic      [width-1:0] pin_out    // synchronised copy
);
    logic [width-1:0] meta_q;                // first stage, read only by second

    // first stage catches the pin, second stage settles it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_q  <= {width{reset_val}};
            pin_out <= {width{reset_val}};
        end
        else
        begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule

// ===== core/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides and a level output
`timescale 1ns/1ns
module byte_fifo #(
    parameter int width = 8,                      // word width
    parameter int depth = 8                       // words held
) (
    input  wire logic                   sys_clk,  // system clock
    input  wire logic                   rst,      // synchronous reset, empties fifo
    input  wire logic [width-1:0]       in_data,  // word to store
    input  wire logic                   in_valid, // store request
    output logic                        in_ready, // room available
    output logic [width-1:0]            out_data, // oldest word
    output logic                        out_valid,// word available
    input  wire logic                   out_ready,// consumer takes word
    output logic [$clog2(depth+1)-1:0]  level     // words held
);
    localparam int aw = $clog2(depth);            // pointer width
    logic [width-1:0] mem [depth];                // storage array
    logic [aw-1:0]    wr_q;                       // write pointer
    logic [aw-1:0]    rd_q;                       // read pointer
    logic [aw:0]      count_q;                    // occupancy
    logic             push;                       // accepted write
    logic             pop;                        // accepted read

    // advance a pointer with wrap at depth
    function automatic logic [aw-1:0] bump(input logic [aw-1:0] p);
        bump = (p == aw'(depth - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (count_q != (aw+1)'(depth));
    assign out_valid = (count_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q];
    assign level     = count_q;

    // storage write, no reset needed for data
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    // pointers and occupancy
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= bump(wr_q);
            if (pop)
                rd_q <= bump(rd_q);
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule

// ===== verification/port_properties.sv
// concurrent checks on the parallel host register port pins
`timescale 1ns/1ns
module port_properties #(
    parameter int depth     = 8,   // audio fifo words
    parameter int threshold = 6    // almost-full level
) (
    input wire logic       sys_clk,                  // system clock
    input wire logic       rst,                      // synchronous reset
    input wire logic       bus_style,                // strobe style
    input wire logic       chip_select_n,            // chip select
    input wire logic       read_strobe_n,            // read strobe
    input wire logic       read_not_write,           // direction
    input wire logic [1:0] reg_addr,                 // register address
    input wire logic [7:0] data_out,                 // read byte
    input wire logic       data_oe,                  // pins driven
    input wire logic       host_interrupt_request_n, // interrupt, low active
    input wire logic       dsp_inbox_read,           // dsp takes inbox
    input wire logic       dsp_outbox_write,         // dsp loads outbox
    input wire logic       dsp_notify_enable,        // interrupt enable
    input wire logic       inbound_busy,             // inbox flag
    input wire logic       outbound_ready,           // outbox flag
    input wire logic       pcm_out_valid,            // pcm word ready
    input wire logic       cmp_out_valid,            // compressed word ready
    input wire logic       pcm_channel_reset,        // pcm held
    input wire logic       compressed_channel_reset  // compressed held
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // host quiet long enough that no write end is still in the synchroniser
    sequence cs_idle;
        chip_select_n [*6];
    endsequence
    // a read cycle of a readable register is open on the pins
    sequence read_open;
        !reg_addr[1] && !chip_select_n && (bus_style ? read_not_write : !read_strobe_n);
    endsequence
    // reset must win even while the design is held, so no disable here
    a_reset_quiet: assert property (disable iff (1'h0) rst |=> !data_oe && host_interrupt_request_n
        && !inbound_busy && !outbound_ready && !pcm_out_valid && !cmp_out_valid)
        else $error("outputs not idle after reset");
    a_read_source: assert property ($rose(data_oe) |-> read_open)
        else $error("pins driven outside a readable read");
    a_oe_release: assert property (chip_select_n [*4] |=> !data_oe)
        else $error("pins still driven after strobe rise");
    a_read_hold: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
        else $error("read byte moved while driven");
    a_irq_asserts: assert property (outbound_ready && $past(outbound_ready) && $past(dsp_notify_enable)
        && $past(dsp_notify_enable, 2) |-> !host_interrupt_request_n) else $error("interrupt missing");
    a_irq_quiet: assert property (!outbound_ready && !$past(outbound_ready) |-> host_interrupt_request_n)
        else $error("interrupt without outgoing byte");
    a_busy_clear: assert property (cs_idle ##0 dsp_inbox_read |-> ##[1:3] !inbound_busy)
        else $error("inbound busy not cleared");
    a_ready_set: assert property (dsp_outbox_write |-> ##[1:3] outbound_ready)
        else $error("outbound ready not set");
    a_pcm_flush: assert property (pcm_channel_reset [*2] |-> !pcm_out_valid)
        else $error("pcm fifo not held empty");
    a_cmp_flush: assert property (compressed_channel_reset [*2] |-> !cmp_out_valid)
        else $error("compressed fifo not held empty");
endmodule

bind parallel_host_register_port port_properties #(.depth(depth), .threshold(threshold)) prop_u (.*);

// ===== verification/host_bus_model.sv
// host processor model driving the parallel port pins in either bus style
`timescale 1ns/1ns
module host_bus_model (
    input  wire logic       sys_clk,        // system clock
    input  wire logic [7:0] data_out,       // device read byte
    input  wire logic       data_oe,        // device drives pins
    output logic            bus_style,      // strobe style select
    output logic            chip_select_n,  // chip select
    output logic            write_strobe_n, // write strobe
    output logic            read_strobe_n,  // read strobe
    output logic            data_strobe_n,  // data strobe
    output logic            read_not_write, // direction, high read
    output logic      [1:0] reg_addr,       // register address
    output logic      [7:0] data_in         // resolved data pins
);
    logic [7:0] host_d;   // byte placed by host
    logic       host_drv; // host drives pins
    logic [7:0] junk_q;   // floating pin pattern
    assign data_in = data_oe ? data_out : (host_drv ? host_d : junk_q);
    // no pull on the pins, so released pins keep changing
    always @(posedge sys_clk)
        junk_q <= ~junk_q;
    // idle pins at time zero
    initial
    begin
        {chip_select_n, write_strobe_n, read_strobe_n, data_strobe_n, read_not_write} = 5'h1f;
        {bus_style, reg_addr, host_d, host_drv, junk_q} = 20'h0003c;
    end
    task automatic open_cycle(input logic s, input logic [1:0] a, input logic dir);
        @(posedge sys_clk);
        bus_style <= s;
        reg_addr <= a;
        read_not_write <= dir;
        repeat (3) @(posedge sys_clk);
        chip_select_n <= 1'h0;
        write_strobe_n <= s | dir;
        read_strobe_n <= s | !dir;
        data_strobe_n <= !s;
    endtask
    // strobes low then high for well over the four cycles asked
    task automatic close_cycle();
        repeat (5) @(posedge sys_clk);
        {chip_select_n, write_strobe_n, read_strobe_n, data_strobe_n} <= 4'hf;
        host_drv <= 1'h0;
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic wr(input logic s, input logic [1:0] a, input logic [7:0] d);
        open_cycle(s, a, 1'h0);
        @(posedge sys_clk);
        host_d <= d;
        host_drv <= 1'h1;
        close_cycle();
    endtask
    task automatic rd(input logic s, input logic [1:0] a);
        open_cycle(s, a, 1'h1);
        close_cycle();
    endtask
endmodule

// ===== verification/parallel_host_register_port_bench.sv
// self-checking bench for the parallel host register port
`timescale 1ns/1ns
module parallel_host_register_port_bench;
    localparam int th = 6;                         // almost-full level set below
    logic       sys_clk, rst, dsp_inbox_read, dsp_outbox_write, dsp_notify_enable, pcm_out_ready, cmp_out_ready;
    logic [7:0] dsp_outbox_data, b;                // dsp byte, scratch byte
    logic       oe_q;                              // data_oe last cycle
    logic [7:0] rq[$], pq[$], cq[$];               // expected read, pcm, compressed bytes
    int         bad_count, checks;                 // mismatches, comparisons
    wire        bus_style, chip_select_n, write_strobe_n, read_strobe_n, data_strobe_n, read_not_write;
    wire  [1:0] reg_addr;                          // register address
    wire  [7:0] data_in, data_out, dsp_inbox_data, pcm_out_data, cmp_out_data;
    wire        data_oe, host_interrupt_request_n, inbound_busy, outbound_ready;
    wire        pcm_out_valid, cmp_out_valid, pcm_channel_reset, compressed_channel_reset;

    parallel_host_register_port #(.depth(8), .threshold(th)) dut_u (.*);
    host_bus_model host_u (.*);

    always #5 sys_clk = ~sys_clk;
    // compare after the edge's updates have landed
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // oldest note of a queue, unknown when nothing was expected
    task automatic chk_pop(input int w, input logic [7:0] got);
        logic [7:0] e;
        e = 8'hxx;
        if (w == 0 && rq.size() > 0) e = rq.pop_front();
        if (w == 1 && pq.size() > 0) e = pq.pop_front();
        if (w == 2 && cq.size() > 0) e = cq.pop_front();
        chk(got, e);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // read monitor: a new drive of the pins carries the oldest noted byte
    always @(posedge sys_clk)
    begin
        oe_q <= data_oe;
        if (data_oe === 1'h1 && oe_q !== 1'h1) chk_pop(0, data_out);
    end
    // fifo drain monitors
    always @(posedge sys_clk)
        if (pcm_out_valid === 1'h1 && pcm_out_ready) chk_pop(1, pcm_out_data);
    always @(posedge sys_clk)
        if (cmp_out_valid === 1'h1 && cmp_out_ready) chk_pop(2, cmp_out_data);
    // hang guard well beyond the few hundred cycles the tests need
    initial
    begin
        #300000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        {sys_clk, rst, dsp_inbox_read, dsp_outbox_write, dsp_notify_enable, pcm_out_ready, cmp_out_ready} = 7'h20;
        {dsp_outbox_data, oe_q, bad_count, checks} = 0;
        void'($urandom(32'hb6830baf));
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        rq.push_back(8'h00);
        host_u.rd(1'h0, host_port_pkg::addr_control);
        chk({7'h00, host_interrupt_request_n}, 8'h01);
        $display("test reset done");
        for (int s = 0; s < 2; s++)
        begin
            b = 8'($urandom());
            host_u.wr(s[0], host_port_pkg::addr_message, b);
            chk({7'h00, inbound_busy}, 8'h01);
            chk(dsp_inbox_data, b);
            rq.push_back(8'h04);
            host_u.rd(s[0], host_port_pkg::addr_control);
            @(posedge sys_clk);
            dsp_inbox_read <= 1'h1;
            @(posedge sys_clk);
            dsp_inbox_read <= 1'h0;
            repeat (3) @(posedge sys_clk);
            chk({7'h00, inbound_busy}, 8'h00);
        end
        $display("test inbox done");
        for (int s = 0; s < 2; s++)
        begin
            b = 8'($urandom());
            @(posedge sys_clk);
            dsp_notify_enable <= s[0];
            dsp_outbox_data <= b;
            dsp_outbox_write <= 1'h1;
            @(posedge sys_clk);
            dsp_outbox_write <= 1'h0;
            repeat (3) @(posedge sys_clk);
            chk({6'h00, outbound_ready, host_interrupt_request_n}, {6'h00, 1'h1, !s[0]});
            rq.push_back(8'h02);
            host_u.rd(s[0], host_port_pkg::addr_control);
            rq.push_back(b);
            host_u.rd(s[0], host_port_pkg::addr_message);
            chk({6'h00, outbound_ready, host_interrupt_request_n}, 8'h01);
        end
        $display("test outbox done");
        for (int c = 2; c < 4; c++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                if (i == th - 1) rq.push_back(8'h00);
                if (i == th - 1) host_u.rd(1'h1, host_port_pkg::addr_control);
                b = 8'($urandom());
                if (i < 8 && c == 2) pq.push_back(b);
                if (i < 8 && c == 3) cq.push_back(b);
                host_u.wr(i[0], c[1:0], b);
            end
            rq.push_back(c == 2 ? 8'h10 : 8'h08);
            host_u.rd(1'h1, host_port_pkg::addr_control);
            host_u.rd(c[0], c[1:0]);
            @(posedge sys_clk);
            pcm_out_ready <= (c == 2);
            cmp_out_ready <= (c == 3);
            for (int k = 0; k < 20 && pq.size() + cq.size() != 0; k++) @(posedge sys_clk);
            chk(8'(pq.size() + cq.size()), 8'h00);
            pcm_out_ready <= 1'h0;
            cmp_out_ready <= 1'h0;
        end
        $display("test audio done");
        host_u.wr(1'h0, host_port_pkg::addr_pcm, 8'h5a);
        host_u.wr(1'h1, host_port_pkg::addr_compressed, 8'ha5);
        host_u.wr(1'h0, host_port_pkg::addr_control, 8'h60);
        chk({6'h00, compressed_channel_reset, pcm_channel_reset}, 8'h03);
        rq.push_back(8'h00);
        host_u.rd(1'h1, host_port_pkg::addr_control);
        host_u.wr(1'h1, host_port_pkg::addr_control, 8'h00);
        chk({4'h0, compressed_channel_reset, pcm_channel_reset, cmp_out_valid, pcm_out_valid}, 8'h00);
        $display("test channel reset done");
        print_verdict();
    end
endmodule
